/* File: src/audio_fifo_block_controller.sv */
// audio fifo block controller: per-fifo sample and block counting, memory steering
//
// Behaviour
// - up to eight fifos, four in first_fifo_memory and four in second_fifo_memory.
// - once configured, every sample access to an enabled fifo is steered to memory without software help.
// - each fifo keeps a counter of samples moved by the audio_dma_unit.
// - on a full block: raise that fifo's interrupt, bump block counter, advance pointer.
// - fifo interrupts go out to the dsp_core interrupt controller.
`timescale 1ns/10ps
module audio_fifo_block_controller
  import audio_fifo_pkg::*;
#(
  parameter int NUM_FIFOS = `AFC_NUM_FIFOS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration from the dsp_core
  input wire logic [NUM_FIFOS-1:0] fifo_en_i,
  input wire logic [NUM_FIFOS-1:0][`AFC_ADDR_W-1:0] base_i,
  input wire logic [NUM_FIFOS-1:0][`AFC_ADDR_W-1:0] length_i,
  input wire logic [NUM_FIFOS-1:0][`AFC_ADDR_W-1:0] block_size_i,
  // sample accesses from the audio_dma_unit
  input wire logic dma_valid_i,
  input wire logic [`AFC_IDX_W-1:0] dma_fifo_i,
  input wire logic dma_write_i,
  input wire logic [`AFC_DATA_W-1:0] dma_data_i,
  output logic dma_ready_o,
  // fifo memory port
  output logic mem_valid_o,
  output logic mem_sel_o,
  output logic mem_write_o,
  output logic [`AFC_ADDR_W-1:0] mem_addr_o,
  output logic [`AFC_DATA_W-1:0] mem_data_o,
  input wire logic mem_ready_i,
  // block events
  output logic [NUM_FIFOS-1:0] irq_o,
  output logic [NUM_FIFOS-1:0] chain_event_o,
  output logic [NUM_FIFOS-1:0][`AFC_BLKCNT_W-1:0] block_count_o,
  output logic [NUM_FIFOS-1:0][`AFC_ADDR_W-1:0] sample_count_o
);
  // modulo add inside one memory; sizes are 10 bits so the carry is dropped on purpose
  function automatic logic [`AFC_ADDR_W-1:0] add_addr(input logic [`AFC_ADDR_W-1:0] a,
                                                      input logic [`AFC_ADDR_W-1:0] b);
    logic [`AFC_ADDR_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    return sum[`AFC_ADDR_W-1:0];
  endfunction : add_addr

  ctrl_state_type s_q;
  ctrl_state_type s_d;
  mem_req_type req;
  mem_req_type out_req;
  logic buf_ready;
  logic buf_valid;
  logic accept;
  logic [`AFC_IDX_W-1:0] idx;
  logic [`AFC_ADDR_W-1:0] next_count;
  logic [`AFC_ADDR_W-1:0] next_ptr;
  logic block_done;

  assign idx = dma_fifo_i;
  // accesses to a disabled fifo are consumed and dropped so the dma never hangs
  assign accept = dma_valid_i & buf_ready & fifo_en_i[idx];
  assign next_count = add_addr(s_q.count[idx], `AFC_ONE_ADDR);
  // a block size of zero ends a block on every sample as one does, but the pointer does not advance
  assign block_done = next_count >= block_size_i[idx];
  assign next_ptr = add_addr(s_q.ptr[idx], block_size_i[idx]);

  always_comb begin
    req.sel = idx[`AFC_MEM_SEL_BIT];
    req.write = dma_write_i;
    req.addr = add_addr(base_i[idx], add_addr(s_q.ptr[idx], s_q.count[idx]));
    req.data = dma_data_i;
  end

  always_comb begin
    s_d = s_q;
    s_d.irq = '0;
    s_d.event_out = '0;
    if (accept) begin
      if (block_done) begin
        s_d.count[idx] = `AFC_RST_COUNT;
        s_d.blocks[idx] = s_q.blocks[idx] + `AFC_ONE_BLK;
        // pointer wraps to the fifo start when the next block would start at or past length_i
        if (next_ptr >= length_i[idx] || next_ptr < s_q.ptr[idx]) begin
          s_d.ptr[idx] = `AFC_RST_PTR;
        end else begin
          s_d.ptr[idx] = next_ptr;
        end
        s_d.irq[idx] = 1'b1;
        s_d.event_out[idx] = 1'b1;
      end else begin
        s_d.count[idx] = next_count;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // the buffer lets a memory stall hold two accesses before the dma sees back-pressure
  two_entry_buffer #(
    .WIDTH($bits(mem_req_type))
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(dma_valid_i & fifo_en_i[idx]),
    .in_data_i(req),
    .in_ready_o(buf_ready),
    .out_valid_o(buf_valid),
    .out_data_o(out_req),
    .out_ready_i(mem_ready_i)
  );

  assign dma_ready_o = buf_ready;
  assign mem_valid_o = buf_valid;
  assign mem_sel_o = out_req.sel;
  assign mem_write_o = out_req.write;
  assign mem_addr_o = out_req.addr;
  assign mem_data_o = out_req.data;
  assign irq_o = s_q.irq;
  assign chain_event_o = s_q.event_out;
  assign block_count_o = s_q.blocks;
  assign sample_count_o = s_q.count;
endmodule : audio_fifo_block_controller

/* File: src/audio_fifo_cfg.svh */
// constants for the audio fifo block controller
`ifndef AUDIO_FIFO_CFG_SVH
`define AUDIO_FIFO_CFG_SVH
`define AFC_NUM_FIFOS 8
`define AFC_FIFOS_PER_MEM 4
`define AFC_IDX_W 3
`define AFC_MEM_SEL_BIT 2
`define AFC_ADDR_W 10
`define AFC_DATA_W 48
`define AFC_BLKCNT_W 16
`define AFC_RST_COUNT 10'h000
`define AFC_RST_PTR 10'h000
`define AFC_RST_BLKCNT 16'h0000
`define AFC_ONE_ADDR 10'h001
`define AFC_ONE_BLK 16'h0001
`endif

/* File: src/audio_fifo_pkg.sv */
// types for the audio fifo block controller
`include "audio_fifo_cfg.svh"
package audio_fifo_pkg;
  typedef logic [`AFC_ADDR_W-1:0] addr_type;
  typedef logic [`AFC_DATA_W-1:0] data_type;
  typedef struct packed {
    logic sel;
    logic write;
    addr_type addr;
    data_type data;
  } mem_req_type;
  typedef struct packed {
    logic [`AFC_NUM_FIFOS-1:0][`AFC_ADDR_W-1:0] count;
    logic [`AFC_NUM_FIFOS-1:0][`AFC_ADDR_W-1:0] ptr;
    logic [`AFC_NUM_FIFOS-1:0][`AFC_BLKCNT_W-1:0] blocks;
    logic [`AFC_NUM_FIFOS-1:0] irq;
    logic [`AFC_NUM_FIFOS-1:0] event_out;
  } ctrl_state_type;
endpackage : audio_fifo_pkg

/* File: src/two_entry_buffer.sv */
// two-entry buffer with valid/ready on both sides, outputs from flops
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter int WIDTH = 64
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic head_valid;
    logic tail_valid;
  } buf_state_type;

  buf_state_type s_q;
  buf_state_type s_d;
  logic push;
  logic pop;

  // ready is the registered "not full", so it never depends on out_ready_i
  assign push = in_valid_i & ~s_q.tail_valid;
  assign pop = s_q.head_valid & out_ready_i;
  assign in_ready_o = ~s_q.tail_valid;
  assign out_valid_o = s_q.head_valid;
  assign out_data_o = s_q.head;

  always_comb begin
    s_d = s_q;
    if (pop) begin
      s_d.head = s_q.tail;
      s_d.head_valid = s_q.tail_valid;
      s_d.tail_valid = 1'b0;
    end
    if (push) begin
      if (!s_d.head_valid) begin
        s_d.head = in_data_i;
        s_d.head_valid = 1'b1;
      end else begin
        s_d.tail = in_data_i;
        s_d.tail_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : two_entry_buffer

/* File: tb/audio_fifo_block_controller_test.sv */
// self-checking bench for the audio fifo block controller
`timescale 1ns/10ps
module audio_fifo_block_controller_test;
  logic clk_i = 0, rst_i = 1, dma_valid_i = 0, dma_write_i = 1, stall = 0;
  logic dma_ready_o, mem_valid_o, mem_sel_o, mem_write_o, mem_ready_i;
  logic [7:0] fifo_en_i = 8'hFF, irq_o, chain_event_o;
  logic [7:0][9:0] base_i = '0, length_i = {8{10'h064}}, block_size_i = {8{10'h3FF}}, sample_count_o;
  logic [2:0] dma_fifo_i = 3'h0;
  logic [47:0] dma_data_i = 48'h0, mem_data_o;
  logic [9:0] mem_addr_o;
  logic [7:0][15:0] block_count_o;
  logic [10:0] last;
  int taken, errors = 0, checks = 0, cyc = 0, n;
  int irqs = 0, events = 0;
  logic [48:0] last_wd;
  initial forever #5 clk_i = ~clk_i;
  audio_fifo_block_controller u_dut (.*);
  mem_model u_mem (.clk_i(clk_i), .valid_i(mem_valid_o), .sel_i(mem_sel_o), .addr_i(mem_addr_o),
    .stall_i(stall), .ready_o(mem_ready_i), .last_o(last), .taken_o(taken));
  // pulses last one cycle, so they are counted at every rising edge
  always @(posedge clk_i) begin
    if (!rst_i) begin
      irqs += $countones(irq_o);
      events += $countones(chain_event_o);
    end
    if (mem_valid_o && mem_ready_i) last_wd <= {mem_write_o, mem_data_o};
  end
  task chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // request stays up after the take so back-to-back calls need no gap
  task acc(input logic [2:0] f);
    dma_fifo_i = f;
    dma_data_i = {45'h0, f};
    dma_valid_i = 1;
    while (dma_ready_o !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
  endtask : acc
  task wait_taken(input int k);
    repeat (20) if (taken < k) @(negedge clk_i);
  endtask : wait_taken
  task t_blocks;
    acc(3'h0);
    acc(3'h0);
    dma_valid_i = 0;
    wait_taken(2);
    chk("addr0", {37'h0, 11'h011}, last);
    chk("blocks0", 48'h1, block_count_o[0]);
    acc(3'h0);
    dma_valid_i = 0;
    wait_taken(3);
    chk("ptr0", {37'h0, 11'h012}, last);
    chk("count0", 48'h1, sample_count_o[0]);
    acc(3'h5);
    dma_valid_i = 0;
    wait_taken(4);
    chk("addr5", {37'h0, 11'h403}, last);
    chk("blocks5", 48'h1, block_count_o[5]);
    chk("data5", 48'h5, last_wd[47:0]);
    chk("write5", 48'h1, {47'h0, last_wd[48]});
    chk("irqs", 48'h2, irqs);
    chk("events", 48'h2, events);
  endtask : t_blocks
  task t_stall;
    stall = 1;
    dma_write_i = 0;
    n = 0;
    dma_fifo_i = 3'h1;
    dma_valid_i = 1;
    repeat (6) begin
      if (dma_ready_o === 1'b1) n++;
      @(negedge clk_i);
    end
    dma_valid_i = 0;
    chk("accepted", 48'h2, n);
    chk("count1", 48'h2, sample_count_o[1]);
    stall = 0;
    wait_taken(6);
    chk("drained", 48'h6, taken);
    chk("ready", 48'h1, dma_ready_o);
    chk("read1", 48'h0, {47'h0, last_wd[48]});
    dma_write_i = 1;
  endtask : t_stall
  task t_off;
    fifo_en_i[0] = 0;
    acc(3'h0);
    dma_valid_i = 0;
    wait_taken(7);
    chk("dropped", 48'h6, taken);
    chk("count0off", 48'h1, sample_count_o[0]);
    fifo_en_i[0] = 1;
  endtask : t_off
  task tally_and_finish;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    base_i[0] = 10'h010;
    base_i[5] = 10'h003;
    block_size_i[0] = 10'h002;
    block_size_i[5] = 10'h001;
    repeat (4) @(negedge clk_i);
    rst_i = 0;
    t_blocks();
    t_stall();
    t_off();
    tally_and_finish();
  end
endmodule : audio_fifo_block_controller_test
bind audio_fifo_block_controller fifo_chk u_chk (.*);

/* File: tb/fifo_chk_properties.sv */
// port assertions for the fifo controller
`timescale 1ns/10ps
module fifo_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] fifo_en_i,
  input wire logic [7:0][9:0] block_size_i,
  input wire logic dma_valid_i,
  input wire logic [2:0] dma_fifo_i,
  input wire logic dma_ready_o,
  input wire logic mem_valid_o,
  input wire logic [9:0] mem_addr_o,
  input wire logic mem_ready_i,
  input wire logic [7:0] irq_o,
  input wire logic [7:0] chain_event_o,
  input wire logic [7:0][15:0] block_count_o,
  input wire logic [7:0][9:0] sample_count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    dma_valid_i && dma_ready_o && dma_fifo_i == 3'h0;
  endsequence
  sequence s_mid;
    s_take ##0 fifo_en_i[0] && sample_count_o[0] + 10'h001 < block_size_i[0];
  endsequence
  sequence s_end;
    s_take ##0 fifo_en_i[0] && !(sample_count_o[0] + 10'h001 < block_size_i[0]);
  endsequence
  property p_count; s_mid |=> sample_count_o[0] == $past(sample_count_o[0]) + 10'h001; endproperty
  property p_done; s_end |=> irq_o[0] && sample_count_o[0] == 10'h000; endproperty
  property p_blk; s_end |=> block_count_o[0] == $past(block_count_o[0]) + 16'h0001; endproperty
  property p_quiet; !(dma_valid_i && dma_ready_o && dma_fifo_i == 3'h0) |=> !irq_o[0]; endproperty
  property p_evt; irq_o == chain_event_o; endproperty
  property p_hold; mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_addr_o); endproperty
  property p_off; s_take ##0 !fifo_en_i[0] |=> $stable(sample_count_o[0]) && !irq_o[0]; endproperty
  a_count: assert property (p_count) else $error("sample count");
  a_done: assert property (p_done) else $error("block end");
  a_blk: assert property (p_blk) else $error("block count");
  a_quiet: assert property (p_quiet) else $error("stray irq");
  a_evt: assert property (p_evt) else $error("irq vs event");
  a_hold: assert property (p_hold) else $error("mem hold");
  a_off: assert property (p_off) else $error("disabled fifo");
endmodule : fifo_chk

/* File: tb/mem_model.sv */
// behavioural fifo memory on the controller's memory port
`timescale 1ns/10ps
module mem_model (
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic sel_i,
  input wire logic [9:0] addr_i,
  input wire logic stall_i,
  output logic ready_o,
  output logic [10:0] last_o,
  output int taken_o
);
  initial taken_o = 0;
  // stalls only when the bench asks, to fill the buffer
  assign ready_o = !stall_i;
  always @(posedge clk_i) if (valid_i && ready_o) begin
    last_o <= {sel_i, addr_i};
    taken_o <= taken_o + 1;
  end
endmodule : mem_model
